// ===== verilog/rsc_pkg.sv
/*
   Package for the reset source combiner: register offsets, the bit layout of the
   reset cause register, values after reset, masks and reset stretch timing.
   Assumes a 125 MHz pclk and a 12-bit APB byte address.
*/
`default_nettype none

package rsc_pkg;

   // ----------------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------------
   localparam int unsigned    APB_AW       = 12;
   localparam int unsigned    CAUSE_W      = 16;
   localparam logic [11:0]    CAUSE_OFS    = 12'h000;

   // ----------------------------------------------------------------------
   // reset cause register bit positions
   // ----------------------------------------------------------------------
   localparam int unsigned    POWER_ON_FLAG_BIT          = 0;
   localparam int unsigned    BROWNOUT_FLAG_BIT          = 1;
   localparam int unsigned    IDLE_WAKE_FLAG_BIT         = 2;
   localparam int unsigned    SLEEP_WAKE_FLAG_BIT        = 3;
   localparam int unsigned    WATCHDOG_TIMEOUT_FLAG_BIT  = 4;
   localparam int unsigned    WATCHDOG_SOFT_ENABLE_BIT   = 5;
   localparam int unsigned    SOFT_RESET_FLAG_BIT        = 6;
   localparam int unsigned    EXTERNAL_PIN_FLAG_BIT      = 7;
   localparam int unsigned    REGULATOR_SLEEP_ACTIVE_BIT = 8;
   localparam int unsigned    CONFIG_MISMATCH_FLAG_BIT   = 9;
   localparam int unsigned    ILLEGAL_OPERATION_FLAG_BIT = 14;
   localparam int unsigned    TRAP_CONFLICT_FLAG_BIT     = 15;

   // ----------------------------------------------------------------------
   // values and masks
   // ----------------------------------------------------------------------
   localparam logic [15:0]    CAUSE_POR_VAL  = 16'h0001;
   localparam logic [15:0]    CAUSE_IMPL     = 16'hC3FF;
   // flags a brown-out clears: not external pin, brown-out, power-on, controls
   localparam logic [15:0]    BOR_CLR_MASK   = 16'hC25C;
   localparam logic [15:0]    WATCHDOG_TIMEOUT_FLAG_CLR_MASK  = 16'h0010;

   // ----------------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------------
   localparam int unsigned    CLK_MHZ        = 125;
   localparam int unsigned    TRST_US        = 20;
   localparam int unsigned    TRST_CYCLES    = TRST_US * CLK_MHZ;
   localparam int unsigned    HOLD_W         = 12;

   typedef enum logic [1:0] {
      RSC_SRC_ACTIVE,
      RSC_HOLD,
      RSC_RUN
   } rsc_state_t;

endpackage : rsc_pkg

`default_nettype wire

// ===== verilog/rsc_flag_if.sv
/*
   Carrier between the combiner top and its flag bank: per-bit set, clear and
   software write strobes, a power-on load, and the stored bits.
   Assumes both ends run on the same pclk.
*/
`default_nettype none

interface rsc_flag_if #(
   parameter int unsigned WIDTH = 16
);
   logic [WIDTH-1:0] hw_set;
   logic [WIDTH-1:0] hw_clr;
   logic [WIDTH-1:0] sw_we;
   logic [WIDTH-1:0] sw_val;
   logic [WIDTH-1:0] por_val;
   logic             por_load;
   logic [WIDTH-1:0] q;

   modport bank (
      input  hw_set,
      input  hw_clr,
      input  sw_we,
      input  sw_val,
      input  por_val,
      input  por_load,
      output q
   );

   modport ctl (
      output hw_set,
      output hw_clr,
      output sw_we,
      output sw_val,
      output por_val,
      output por_load,
      input  q
   );
endinterface : rsc_flag_if

`default_nettype wire

// ===== verilog/rsc_flag_bank.sv
/*
   Bank of sticky flag bits with hardware set, hardware clear, software write
   and a synchronous power-on load.
   Assumes the control side keeps unimplemented bits out of every strobe.
*/
`default_nettype none

module rsc_flag_bank #(
   parameter int unsigned       WIDTH   = 16,
   parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
   input  wire logic  pclk,
   input  wire logic  presetn,
   rsc_flag_if.bank   flg
);

   logic [WIDTH-1:0] q_ff;
   logic [WIDTH-1:0] nxt_q;
   logic [WIDTH-1:0] kept;

   // ----------------------------------------------------------------------
   // next value
   // ----------------------------------------------------------------------
   // software value first, then hardware clear, then set on top
   assign kept  = (flg.sw_we & flg.sw_val) | (~flg.sw_we & q_ff);
   assign nxt_q = flg.por_load ? (flg.por_val | flg.hw_set)
                               : ((kept & ~flg.hw_clr) | flg.hw_set); // [R20] [R04]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= RST_VAL;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign flg.q = q_ff;

endmodule : rsc_flag_bank

`default_nettype wire

// ===== verilog/rsc_top.sv
/*
   Reset source combiner: merges eight reset sources into one stretched master
   system reset and keeps the reset cause register, reachable over APB.
   Assumes all source inputs are synchronous to pclk and presetn is power-on.
*/
// Local design decisions: the APB slave port and the register offsets.
// What this block does
// [R01] any active source asserts master system reset
// [R02] eight reset sources are accepted
// [R03] each reset kind sets its own flag
// [R04] power-on clears all but power-on flag
// [R05] software sets or clears bits, no reset
// [R06] other resets leave register contents alone; here brown-out clears the BOR_CLR_MASK flags
// [R07] trap conflict sets bit 15
// [R08] illegal operation sets bit 14
// [R09] configuration mismatch sets bit 9
// [R10] bit 8 keeps regulator active in sleep
// [R11] master clear pin sets bit 7
// [R12] reset instruction sets bit 6
// [R13] bit 5 or fuse enables watchdog
// [R14] watchdog time-out sets bit 4
// [R15] sleep entry sets bit 3
// [R16] idle entry sets bit 2
// [R17] software should clear flags after reading
// [R18] brown-out sets bit 1
// [R19] flag clearing events per flag
// [R20] hardware set beats software write
`default_nettype none

module rsc_top (
   input  wire logic         pclk,
   input  wire logic         presetn,
   // apb slave
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   input  wire logic [3:0]   pstrb,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   // reset sources
   input  wire logic         por_req,
   input  wire logic         brownout_req,
   input  wire logic         master_clear_pin_n,
   input  wire logic         reset_instr,
   input  wire logic         wdt_timeout,
   input  wire logic         trap_conflict,
   input  wire logic         illegal_op,
   input  wire logic         config_mismatch,
   // power state and watchdog events
   input  wire logic         sleep_entry,
   input  wire logic         idle_entry,
   input  wire logic         power_save_instruction,
   input  wire logic         watchdog_clear_instruction,
   input  wire logic         watchdog_fuse_enable,
   // outputs to the rest of the device
   output logic              master_system_reset,
   output logic              watchdog_enable,
   output logic              regulator_sleep_active
);

   // ----------------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------------
   localparam int unsigned W = rsc_pkg::CAUSE_W;

   rsc_flag_if #(.WIDTH(W)) flg ();

   logic [W-1:0]              cause_q;
   logic [W-1:0]              set_vec;
   logic [W-1:0]              clr_vec;
   logic [W-1:0]              lane_mask;
   logic                      src_any;
   logic                      master_clear_pin_active;

   logic                      apb_setup;
   logic                      apb_access;
   logic                      addr_hit;
   logic                      apb_wr;
   logic [31:0]               rd_word;

   logic [31:0]               prdata_ff;
   logic                      pslverr_ff;

   rsc_pkg::rsc_state_t       state_ff;
   rsc_pkg::rsc_state_t       nxt_state;
   logic [rsc_pkg::HOLD_W-1:0] hold_cnt_ff;
   logic [rsc_pkg::HOLD_W-1:0] nxt_hold_cnt;
   logic                      hold_done;
   logic                      master_rst_ff;
   logic                      wdt_en_ff;

   localparam logic [rsc_pkg::HOLD_W-1:0] HOLD_LAST =
      rsc_pkg::HOLD_W'(rsc_pkg::TRST_CYCLES - 1);

   // ----------------------------------------------------------------------
   // reset sources
   // ----------------------------------------------------------------------
   assign master_clear_pin_active = ~master_clear_pin_n;

   assign src_any = por_req
                  | brownout_req
                  | master_clear_pin_active
                  | reset_instr
                  | wdt_timeout
                  | trap_conflict
                  | illegal_op
                  | config_mismatch; // [R01] [R02]

   // ----------------------------------------------------------------------
   // hardware set of cause flags
   // ----------------------------------------------------------------------
   // sources are levels; the flag stays set as long as the source is held
   assign set_vec[rsc_pkg::POWER_ON_FLAG_BIT]          = 1'b0;
   assign set_vec[rsc_pkg::BROWNOUT_FLAG_BIT]          = brownout_req;    // [R18] [R03]
   assign set_vec[rsc_pkg::IDLE_WAKE_FLAG_BIT]         = idle_entry;      // [R16]
   assign set_vec[rsc_pkg::SLEEP_WAKE_FLAG_BIT]        = sleep_entry;     // [R15]
   assign set_vec[rsc_pkg::WATCHDOG_TIMEOUT_FLAG_BIT]  = wdt_timeout;     // [R14] [R03]
   assign set_vec[rsc_pkg::WATCHDOG_SOFT_ENABLE_BIT]   = 1'b0;
   assign set_vec[rsc_pkg::SOFT_RESET_FLAG_BIT]        = reset_instr;     // [R12] [R03]
   assign set_vec[rsc_pkg::EXTERNAL_PIN_FLAG_BIT]      = master_clear_pin_active;     // [R11] [R03]
   assign set_vec[rsc_pkg::REGULATOR_SLEEP_ACTIVE_BIT] = 1'b0;
   assign set_vec[rsc_pkg::CONFIG_MISMATCH_FLAG_BIT]   = config_mismatch; // [R09] [R03]
   assign set_vec[13:10]                               = 4'h0;
   assign set_vec[rsc_pkg::ILLEGAL_OPERATION_FLAG_BIT] = illegal_op;      // [R08] [R03]
   assign set_vec[rsc_pkg::TRAP_CONFLICT_FLAG_BIT]     = trap_conflict;   // [R07] [R03]

   // ----------------------------------------------------------------------
   // hardware clear of cause flags
   // ----------------------------------------------------------------------
   // external pin flag survives brown-out; only power-on or a software write clears it
   assign clr_vec = ({W{brownout_req}} & rsc_pkg::BOR_CLR_MASK)
                  | ({W{power_save_instruction | watchdog_clear_instruction}}
                     & rsc_pkg::WATCHDOG_TIMEOUT_FLAG_CLR_MASK); // [R19]

   // ----------------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------------
   assign apb_setup  = psel & ~penable;
   assign apb_access = psel & penable;
   assign addr_hit   = (paddr[11:2] == rsc_pkg::CAUSE_OFS[11:2]);
   assign apb_wr     = apb_access & pwrite & addr_hit;
   assign lane_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
   assign rd_word    = addr_hit ? {16'h0000, cause_q & rsc_pkg::CAUSE_IMPL} : 32'h0000_0000;

   // ----------------------------------------------------------------------
   // flag bank connection
   // ----------------------------------------------------------------------
   // a software write only stores; nothing here feeds src_any from it
   assign flg.hw_set   = set_vec;
   assign flg.hw_clr   = clr_vec;
   assign flg.sw_we    = {W{apb_wr}} & lane_mask & rsc_pkg::CAUSE_IMPL; // [R05]
   assign flg.sw_val   = pwdata[15:0];
   assign flg.por_val  = rsc_pkg::CAUSE_POR_VAL;
   assign flg.por_load = por_req; // [R04]
   assign cause_q      = flg.q;

   // only presetn and por_req reinitialise it; other sources never load it
   rsc_flag_bank #(
      .WIDTH   (W),
      .RST_VAL (rsc_pkg::CAUSE_POR_VAL)
   ) u_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .flg     (flg)
   ); // [R06] [R04]

   // ----------------------------------------------------------------------
   // apb read data and error
   // ----------------------------------------------------------------------
   // captured in the setup cycle so prdata comes from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else if (apb_setup) begin
         prdata_ff  <= rd_word;
         pslverr_ff <= ~addr_hit;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = apb_access;
   assign pslverr = apb_access & pslverr_ff;

   // ----------------------------------------------------------------------
   // master reset stretch
   // ----------------------------------------------------------------------
   // reset stays on for the internal state reset time after the last source
   assign hold_done = (hold_cnt_ff == HOLD_LAST);

   always_comb begin
      nxt_state    = state_ff;
      nxt_hold_cnt = hold_cnt_ff;
      unique case (state_ff)
         rsc_pkg::RSC_SRC_ACTIVE: begin
            nxt_hold_cnt = '0;
            if (!src_any) begin
               nxt_state = rsc_pkg::RSC_HOLD;
            end
         end
         rsc_pkg::RSC_HOLD: begin
            nxt_hold_cnt = hold_cnt_ff + 1'b1;
            if (hold_done) begin
               nxt_state    = rsc_pkg::RSC_RUN;
               nxt_hold_cnt = '0;
            end
         end
         rsc_pkg::RSC_RUN: begin
            nxt_hold_cnt = '0;
         end
         // unused state code: fall back to holding reset
         default: begin
            nxt_state    = rsc_pkg::RSC_SRC_ACTIVE;
            nxt_hold_cnt = '0;
         end
      endcase
      if (src_any) begin
         nxt_state    = rsc_pkg::RSC_SRC_ACTIVE;
         nxt_hold_cnt = '0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff      <= rsc_pkg::RSC_SRC_ACTIVE;
         hold_cnt_ff   <= '0;
         master_rst_ff <= 1'b1;
      end else begin
         state_ff      <= nxt_state;
         hold_cnt_ff   <= nxt_hold_cnt;
         master_rst_ff <= (nxt_state != rsc_pkg::RSC_RUN); // [R01]
      end
   end

   assign master_system_reset = master_rst_ff;

   // ----------------------------------------------------------------------
   // watchdog and regulator controls
   // ----------------------------------------------------------------------
   // an unprogrammed fuse forces the watchdog on regardless of software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_en_ff <= 1'b0;
      end else begin
         wdt_en_ff <= cause_q[rsc_pkg::WATCHDOG_SOFT_ENABLE_BIT]
                    | watchdog_fuse_enable; // [R13]
      end
   end

   assign watchdog_enable        = wdt_en_ff;
   assign regulator_sleep_active = cause_q[rsc_pkg::REGULATOR_SLEEP_ACTIVE_BIT]; // [R10]

endmodule : rsc_top

`default_nettype wire

// ===== sim/rsc_top_props.sv
/* Port checker for rsc_top: reset raising, flag capture, control outputs.
   Assumes it is bound onto rsc_top, one pclk domain, presetn async low. */
`default_nettype none
module rsc_top_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        por_req,
   input wire logic        brownout_req,
   input wire logic        master_clear_pin_n,
   input wire logic        reset_instr,
   input wire logic        wdt_timeout,
   input wire logic        trap_conflict,
   input wire logic        illegal_op,
   input wire logic        config_mismatch,
   input wire logic        watchdog_fuse_enable,
   input wire logic        master_system_reset,
   input wire logic        watchdog_enable,
   input wire logic        regulator_sleep_active
);
   timeunit 1ns;
   timeprecision 1ps;
   wire any_src = por_req | brownout_req | ~master_clear_pin_n | reset_instr
                | wdt_timeout | trap_conflict | illegal_op | config_mismatch;
   // read data was captured one edge earlier, so flags lag the source by two
   wire rd = psel & penable & ~pwrite & (paddr[11:2] == 10'h000);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_rst; any_src |=> master_system_reset; endproperty
   a_rst: assert property (p_rst) else $error("source without reset");
   property p_hold; !any_src && $past(any_src) |-> master_system_reset [*8]; endproperty
   a_hold: assert property (p_hold) else $error("reset dropped early");
   property p_trap; rd && $past(trap_conflict, 2) |-> prdata[15]; endproperty
   a_trap: assert property (p_trap) else $error("trap flag missing");
   property p_illop; rd && $past(illegal_op, 2) |-> prdata[14]; endproperty
   a_illop: assert property (p_illop) else $error("illegal flag missing");
   property p_cm; rd && $past(config_mismatch, 2) |-> prdata[9]; endproperty
   a_cm: assert property (p_cm) else $error("mismatch flag missing");
   property p_master_clear_pin; rd && !$past(master_clear_pin_n, 2) |-> prdata[7]; endproperty
   a_master_clear_pin: assert property (p_master_clear_pin) else $error("pin flag missing");
   property p_bor; rd && $past(brownout_req, 2) |-> prdata[1]; endproperty
   a_bor: assert property (p_bor) else $error("brown-out flag missing");
   property p_vreg; rd |-> prdata[8] == $past(regulator_sleep_active); endproperty
   a_vreg: assert property (p_vreg) else $error("regulator output wrong");
   property p_wden;
      rd |-> watchdog_enable == (prdata[5] | $past(watchdog_fuse_enable));
   endproperty
   a_wden: assert property (p_wden) else $error("watchdog enable wrong");
   property p_swnr;
      !master_system_reset && !any_src && psel && penable && pwrite |=> !master_system_reset;
   endproperty
   a_swnr: assert property (p_swnr) else $error("write caused reset");
   c_trap: cover property (rd && prdata[15]);
   c_fall: cover property ($fell(master_system_reset));
   c_prio: cover property (psel && penable && pwrite && trap_conflict);
endmodule // rsc_top_props
`default_nettype wire

// ===== sim/rsc_src_model.sv
/* Reset sources and power events around rsc_top, one ev bit per event.
   Assumes the bench changes ev just after a pclk edge. */
`default_nettype none
module rsc_src_model (
   input  wire logic [11:0] ev,
   output logic             por_req,
   output logic             brownout_req,
   output logic             master_clear_pin_n,
   output logic             reset_instr,
   output logic             wdt_timeout,
   output logic             trap_conflict,
   output logic             illegal_op,
   output logic             config_mismatch,
   output logic             sleep_entry,
   output logic             idle_entry,
   output logic             power_save_instruction,
   output logic             watchdog_clear_instruction
);
   timeunit 1ns;
   timeprecision 1ps;
   assign por_req = ev[0];
   assign brownout_req = ev[1];
   // pin idles high, pulled low only for the event
   assign master_clear_pin_n = ~ev[2];
   assign {watchdog_clear_instruction, power_save_instruction, idle_entry, sleep_entry,
           config_mismatch, illegal_op, trap_conflict, wdt_timeout, reset_instr} = ev[11:3];
endmodule // rsc_src_model
`default_nettype wire

// ===== sim/test_rsc_top.sv
/* Self-checking bench for rsc_top: APB master, source events, verdict.
   Assumes rsc_pkg, the source model and the checker are compiled first. */
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
   $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module test_rsc_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, watchdog_fuse_enable = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic [11:0] paddr = '0, ev = '0;
   logic [31:0] pwdata = '0, prdata, rdat;
   logic [3:0]  pstrb = '0;
   logic        por_req, brownout_req, master_clear_pin_n, reset_instr, wdt_timeout;
   logic        trap_conflict, illegal_op, config_mismatch, sleep_entry, idle_entry;
   logic        power_save_instruction, watchdog_clear_instruction;
   logic        master_system_reset, watchdog_enable, regulator_sleep_active;
   int          fail_count = 0, n_compared = 0, cyc = 0;
   logic [15:0] exp_tab [10] = '{16'h0001, 16'h0002, 16'h0080, 16'h0040, 16'h0010,
                                 16'h8000, 16'h4000, 16'h0200, 16'h0008, 16'h0004};
   logic [15:0] pre [4] = '{16'hC3FF, 16'h0010, 16'h0010, 16'hC3FF};
   logic [11:0] clr_ev [4] = '{12'h002, 12'h400, 12'h800, 12'h001};
   logic [15:0] post [4] = '{16'h01A3, 16'h0000, 16'h0000, 16'h0001};
   rsc_src_model i_rsc_src_model (.ev, .por_req, .brownout_req, .master_clear_pin_n,
      .reset_instr, .wdt_timeout, .trap_conflict, .illegal_op, .config_mismatch,
      .sleep_entry, .idle_entry, .power_save_instruction, .watchdog_clear_instruction);
   rsc_top i_rsc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .pstrb, .prdata, .pready, .pslverr, .por_req, .brownout_req, .master_clear_pin_n,
      .reset_instr, .wdt_timeout, .trap_conflict, .illegal_op, .config_mismatch,
      .sleep_entry, .idle_entry, .power_save_instruction, .watchdog_clear_instruction,
      .watchdog_fuse_enable, .master_system_reset, .watchdog_enable, .regulator_sleep_active);
   // ----------------------------------------------------------------
   // clock, hang guard, bus and event tasks
   // ----------------------------------------------------------------
   initial forever #4 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 12000) begin
         fail_count++;
         final_report();
      end
   end
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic fire(input logic [11:0] e);
      ev <= e;
      @(posedge pclk);
      ev <= '0;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_por();
      int n = 0;
      `CHK("reset at release", 1'b1, master_system_reset)
      while (master_system_reset === 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      `CHK("reset stretch", 1'b1, (n > 2400 && n < 3000))
      apb(1'b0, 12'h000, 16'h0000, 4'hF);
      `CHK("power-on value", 32'h0000_0001, rdat)
      $display("t_por done");
   endtask
   task automatic t_sw();
      apb(1'b1, 12'h000, 16'h0000, 4'hF);
      watchdog_fuse_enable <= 1'b1;
      repeat (2) @(posedge pclk);
      `CHK("fuse forces watchdog", 1'b1, watchdog_enable)
      watchdog_fuse_enable <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("watchdog off", 1'b0, watchdog_enable)
      apb(1'b1, 12'h000, 16'hFFFF, 4'h1);
      apb(1'b0, 12'h000, 16'h0000, 4'hF);
      `CHK("low lane only", 32'h0000_00FF, rdat)
      `CHK("regulator standby", 1'b0, regulator_sleep_active)
      apb(1'b1, 12'h000, 16'hFFFF, 4'hF);
      apb(1'b0, 12'h000, 16'h0000, 4'hF);
      `CHK("all writable bits", 32'h0000_C3FF, rdat)
      `CHK("regulator active", 1'b1, regulator_sleep_active)
      `CHK("soft watchdog on", 1'b1, watchdog_enable)
      `CHK("no reset by write", 1'b0, master_system_reset)
      apb(1'b0, 12'h004, 16'h0000, 4'hF);
      `CHK("unmapped data", 32'h0000_0000, rdat)
      `CHK("unmapped error", 1'b1, err)
      $display("t_sw done");
   endtask
   task automatic t_src();
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, 12'h000, 16'h0000, 4'hF);
         // source held through the read so the checker sees it two edges back
         ev <= 12'h001 << i;
         apb(1'b0, 12'h000, 16'h0000, 4'hF);
         ev <= '0;
         `CHK("cause flag", {16'h0000, exp_tab[i]}, rdat)
      end
      $display("t_src done");
   endtask
   task automatic t_clr();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, 12'h000, pre[i], 4'hF);
         fire(clr_ev[i]);
         apb(1'b0, 12'h000, 16'h0000, 4'hF);
         `CHK("clearing event", {16'h0000, post[i]}, rdat)
      end
      $display("t_clr done");
   endtask
   task automatic t_prio();
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= 1'b1;
      paddr <= 12'h000;
      pwdata <= 32'h0000_0000;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      ev <= 12'h020;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      ev <= '0;
      apb(1'b0, 12'h000, 16'h0000, 4'hF);
      `CHK("set beats write", 32'h0000_8000, rdat)
      $display("t_prio done");
   endtask
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_por();
      t_sw();
      t_src();
      t_clr();
      t_prio();
      final_report();
   end
endmodule // test_rsc_top
bind rsc_top rsc_top_props i_rsc_top_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .prdata, .por_req, .brownout_req, .master_clear_pin_n, .reset_instr,
   .wdt_timeout, .trap_conflict, .illegal_op, .config_mismatch, .watchdog_fuse_enable,
   .master_system_reset, .watchdog_enable, .regulator_sleep_active);
`default_nettype wire
